/* File: logic/serial_port_control_status.sv */
`timescale 1ns/1ps
module serial_port_control_status #(
   parameter int TIMER_WIDTH = 16
) (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire logic       cold_reset_n,
   // register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_write,
   input  wire logic       reg_read,
   output logic      [7:0] reg_rdata,
   // serial line
   input  wire logic       rx_pin,
   output logic            tx_pin,
   output logic            shift_clock_out,
   output logic            shift_data_out,
   output logic            shift_data_oe,
   // power requests and interrupt
   output logic            power_down_request,
   output logic            sleep_cpu_request,
   output logic            irq
);
   import serial_port_pkg::*;

   // registers
   logic       baud_doubler_r;
   logic       frame_error_select_r;
   logic       power_off_flag_r;
   logic       gp1_r;
   logic       gp0_r;
   logic       power_down_request_r;
   logic       sleep_cpu_request_r;
   logic       serial_mode_bit0_r;
   logic       serial_mode_bit1_r;
   logic       multiproc_address_filter_r;
   logic       rx_enable_r;
   logic       tx_ninth_bit_r;
   logic       rx_ninth_bit_r;
   logic       tx_done_flag_r;
   logic       rx_done_flag_r;
   logic       framing_error_flag_r;
   logic [7:0] slave_address_r;
   logic [7:0] slave_address_mask_r;
   logic [7:0] rx_data_r;
   logic [7:0] tx_data_r;
   logic [7:0] rdata_r;
   logic [TIMER_WIDTH-1:0] reload_r, timer_r;
   logic [2:0] irq_status_r, irq_mask_r;
   logic       rx_meta_r, rx_sync_r;

   // decode
   wire wr_pc   = reg_write && reg_addr == POWER_CONTROL_ADDR;
   wire wr_sc   = reg_write && reg_addr == SERIAL_PORT_CONTROL_ADDR;
   wire wr_tx   = reg_write && reg_addr == TX_DATA_ADDR;
   wire wr_ist  = reg_write && reg_addr == IRQ_STATUS_ADDR;
   wire wr_sa   = reg_write && reg_addr == SLAVE_ADDRESS_ADDR;
   wire wr_mask = reg_write && reg_addr == SLAVE_ADDRESS_MASK_ADDR;
   wire wr_rld  = reg_write && reg_addr == BAUD_RELOAD_ADDR;
   wire wr_imsk = reg_write && reg_addr == IRQ_MASK_ADDR;
   wire mode_t  mode = mode_t'({serial_mode_bit0_r, serial_mode_bit1_r});

   // baud generation: mode 0 twenty-fourth, mode 2 fixed, modes 1/3 timer overflow / 16 when doubled, / 32 when not
   logic [6:0] pre_cnt_r;
   logic       timer_ovf;
   logic [4:0] var_cnt_r;
   wire  [6:0] fixed_div = baud_doubler_r ? 7'(FIXED_DIV_DOUBLE / OVERSAMPLE)
                                          : 7'(FIXED_DIV_NORMAL / OVERSAMPLE);
   wire  [6:0] pre_div = (mode == MODE_SHIFT) ? 7'(SHIFT_DIV)
                       : (mode == MODE_UART9_FIXED) ? fixed_div : 7'(TIMER_PRESCALE);
   wire        pre_tick = pre_cnt_r >= pre_div - 7'd1;
   assign timer_ovf = pre_tick && (&timer_r);
   // variable modes: oversample tick per timer overflow, halved when not doubled
   wire [4:0] var_div = baud_doubler_r ? 5'd1 : 5'd2;
   wire var_tick = timer_ovf && (var_cnt_r >= var_div - 5'd1);
   wire os_tick = (mode == MODE_UART8 || mode == MODE_UART9_VAR) ? var_tick
                : (mode == MODE_UART9_FIXED) ? pre_tick : 1'b0;
   wire shift_tick = (mode == MODE_SHIFT) && pre_tick;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pre_cnt_r <= 7'h00;
         timer_r   <= '0;
         var_cnt_r <= 5'h00;
      end else begin
         pre_cnt_r <= pre_tick ? 7'h00 : pre_cnt_r + 7'd1;
         if (pre_tick) timer_r <= (&timer_r) ? reload_r : timer_r + 1'b1;
         if (timer_ovf) var_cnt_r <= var_tick ? 5'h00 : var_cnt_r + 5'd1;
      end
   end

   // receive line synchroniser
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
      end else begin
         rx_meta_r <= rx_pin;
         rx_sync_r <= rx_meta_r;
      end
   end

   // transmitter
   logic [10:0] tx_shift_r;
   logic [3:0]  tx_bits_r, tx_os_r;
   logic        tx_busy_r, tx_pin_r, sclk_r;
   wire  [3:0]  tx_frame_bits = (mode == MODE_UART8) ? 4'd10 : 4'd11;
   wire         tx_bit_end = tx_busy_r && os_tick && tx_os_r == 4'd15;
   // transmit-done rises as the stop bit reaches the pin
   wire         tx_stop_start = tx_busy_r && os_tick && tx_os_r == 4'd0 &&
                                tx_bits_r == tx_frame_bits - 4'd1;
   wire         tx_shift_end = tx_busy_r && shift_tick && !sclk_r && tx_bits_r == 4'd7;
   wire         tx_set = (mode == MODE_SHIFT) ? tx_shift_end : tx_stop_start;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tx_shift_r <= 11'h7FF;
         tx_bits_r  <= 4'h0;
         tx_os_r    <= 4'h0;
         tx_busy_r  <= 1'b0;
         tx_pin_r   <= 1'b1;
         sclk_r     <= 1'b1;
      end else if (wr_tx && !tx_busy_r) begin
         // stop, ninth, data, start (lsb out first)
         tx_shift_r <= {1'b1, tx_ninth_bit_r, reg_wdata, 1'b0};
         if (mode == MODE_UART8) tx_shift_r <= {2'b11, reg_wdata, 1'b0};
         if (mode == MODE_SHIFT) tx_shift_r <= {3'b111, reg_wdata};
         tx_busy_r  <= 1'b1;
         tx_bits_r  <= 4'h0;
         tx_os_r    <= 4'h0;
      end else if (tx_busy_r && mode == MODE_SHIFT) begin
         if (shift_tick) begin
            sclk_r <= ~sclk_r;
            // shift on the rising clock so data is stable while it falls
            if (!sclk_r) begin
               tx_shift_r <= {1'b1, tx_shift_r[10:1]};
               tx_bits_r  <= tx_bits_r + 4'd1;
               if (tx_bits_r == 4'd7) tx_busy_r <= 1'b0;
            end
         end
      end else if (tx_busy_r && os_tick) begin
         tx_os_r <= tx_os_r + 4'd1;
         if (tx_os_r == 4'd0) tx_pin_r <= tx_shift_r[0];
         if (tx_bit_end) begin
            tx_shift_r <= {1'b1, tx_shift_r[10:1]};
            tx_bits_r  <= tx_bits_r + 4'd1;
            if (tx_bits_r == tx_frame_bits - 4'd1) tx_busy_r <= 1'b0;
         end
      end
   end

   // receiver
   typedef enum logic [1:0] {RX_IDLE, RX_BITS, RX_STOP} rx_state_t;
   rx_state_t   rx_state_r;
   logic [3:0]  rx_os_r, rx_cnt_r;
   logic [8:0]  rx_shift_r;
   wire  [3:0]  rx_data_bits = (mode == MODE_UART8) ? 4'd8 : 4'd9;
   wire         rx_mid = os_tick && rx_os_r == 4'd7;
   wire  [7:0]  rx_byte = (mode == MODE_UART8) ? rx_shift_r[8:1] : rx_shift_r[7:0];
   wire         rx_ninth = rx_shift_r[8];
   // address recognition
   wire  [7:0]  given = slave_address_r & slave_address_mask_r;
   wire  [7:0]  bcast = slave_address_r | slave_address_mask_r;
   wire  addr_match = ((rx_byte & slave_address_mask_r) == given) ||
                      ((rx_byte & bcast) == bcast);
   wire  stop_ok = rx_sync_r;
   wire  filt_ok = !multiproc_address_filter_r ? 1'b1
                 : (mode == MODE_UART8) ? (stop_ok && addr_match)
                 : (rx_ninth && addr_match);
   wire  rx_frame_end = rx_state_r == RX_STOP && rx_mid;
   wire  uart_rx_set = rx_frame_end && filt_ok && !rx_done_flag_r;
   wire  fe_set = rx_frame_end && !stop_ok;
   logic shift_rx_done;
   wire  rx_set = (mode == MODE_SHIFT) ? shift_rx_done : uart_rx_set;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_state_r    <= RX_IDLE;
         rx_os_r       <= 4'h0;
         rx_cnt_r      <= 4'h0;
         rx_shift_r    <= 9'h000;
         rx_data_r     <= 8'h00;
         shift_rx_done <= 1'b0;
      end else begin
         shift_rx_done <= 1'b0;
         if (mode == MODE_SHIFT) begin
            // shift mode: sample line on rising shift clock while enabled
            rx_state_r <= RX_IDLE;
            if (rx_enable_r && tx_busy_r && shift_tick && !sclk_r) begin
               rx_shift_r <= {rx_sync_r, rx_shift_r[8:1]};
               if (tx_bits_r == 4'd7) begin
                  rx_data_r     <= {rx_sync_r, rx_shift_r[8:2]};
                  shift_rx_done <= 1'b1;
               end
            end
         end else begin
            case (rx_state_r)
               RX_IDLE: begin
                  rx_os_r <= 4'h0;
                  if (rx_enable_r && !rx_sync_r) rx_state_r <= RX_BITS;
                  rx_cnt_r <= 4'h0;
               end
               RX_BITS: if (os_tick) begin
                  rx_os_r <= rx_os_r + 4'd1;
                  if (rx_mid) begin
                     if (rx_cnt_r == 4'd0 && rx_sync_r) rx_state_r <= RX_IDLE;
                     else if (rx_cnt_r != 4'd0) rx_shift_r <= {rx_sync_r, rx_shift_r[8:1]};
                     rx_cnt_r <= rx_cnt_r + 4'd1;
                     if (rx_cnt_r == rx_data_bits) rx_state_r <= RX_STOP;
                  end
               end
               RX_STOP: if (os_tick) begin
                  rx_os_r <= rx_os_r + 4'd1;
                  if (rx_mid) begin
                     rx_state_r <= RX_IDLE;
                     if (uart_rx_set) rx_data_r <= rx_byte;
                  end
               end
               default: rx_state_r <= RX_IDLE;
            endcase
         end
      end
   end

   // power-off flag: only the cold power-up reset and power control writes touch it
   always_ff @(posedge clock or negedge cold_reset_n) begin
      if (!cold_reset_n) begin
         power_off_flag_r <= 1'b1;
      end else if (wr_pc) begin
         power_off_flag_r <= reg_wdata[PC_POWER_OFF];
      end
   end

   // control registers
   wire sc7_is_fe = frame_error_select_r;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         {baud_doubler_r, frame_error_select_r, gp1_r, gp0_r} <= 4'h0;
         power_down_request_r <= POWER_CONTROL_RESET[PC_POWER_DOWN];
         sleep_cpu_request_r  <= POWER_CONTROL_RESET[PC_SLEEP];
         {serial_mode_bit0_r, serial_mode_bit1_r, multiproc_address_filter_r} <= 3'h0;
         {rx_enable_r, tx_ninth_bit_r} <= 2'h0;
         slave_address_r      <= 8'h00;
         slave_address_mask_r <= 8'h00;
         reload_r             <= '0;
         irq_mask_r           <= 3'h0;
      end else begin
         if (wr_pc) begin
            baud_doubler_r       <= reg_wdata[PC_BAUD_DOUBLER];
            frame_error_select_r <= reg_wdata[PC_FRAME_ERR_SEL];
            gp1_r                <= reg_wdata[PC_GP1];
            gp0_r                <= reg_wdata[PC_GP0];
            power_down_request_r <= reg_wdata[PC_POWER_DOWN];
            sleep_cpu_request_r  <= reg_wdata[PC_SLEEP];
         end
         if (wr_sc) begin
            if (!sc7_is_fe) serial_mode_bit0_r <= reg_wdata[SC_BIT7];
            serial_mode_bit1_r         <= reg_wdata[SC_MODE1];
            multiproc_address_filter_r <= reg_wdata[SC_ADDR_FILTER];
            rx_enable_r                <= reg_wdata[SC_RX_ENABLE];
            tx_ninth_bit_r             <= reg_wdata[SC_TX_NINTH];
         end
         if (wr_sa) slave_address_r <= reg_wdata;
         if (wr_mask) slave_address_mask_r <= reg_wdata;
         if (wr_rld) reload_r <= {{(TIMER_WIDTH-8){1'b1}}, reg_wdata};
         if (wr_imsk) irq_mask_r <= reg_wdata[2:0];
      end
   end

   // flags: hardware set wins over a software write in the same cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         framing_error_flag_r <= 1'b0;
         tx_done_flag_r       <= 1'b0;
         rx_done_flag_r       <= 1'b0;
         rx_ninth_bit_r       <= 1'b0;
         irq_status_r         <= 3'h0;
         tx_data_r            <= 8'h00;
      end else begin
         if (fe_set) framing_error_flag_r <= 1'b1;
         else if (wr_sc && sc7_is_fe) framing_error_flag_r <= reg_wdata[SC_BIT7];
         if (tx_set) tx_done_flag_r <= 1'b1;
         else if (wr_sc) tx_done_flag_r <= reg_wdata[SC_TX_DONE];
         if (rx_set) rx_done_flag_r <= 1'b1;
         else if (wr_sc) rx_done_flag_r <= reg_wdata[SC_RX_DONE];
         if (uart_rx_set && mode != MODE_UART8) rx_ninth_bit_r <= rx_ninth;
         else if (uart_rx_set && !multiproc_address_filter_r) rx_ninth_bit_r <= stop_ok;
         else if (wr_sc) rx_ninth_bit_r <= reg_wdata[SC_RX_NINTH];
         irq_status_r <= (irq_status_r & ~(wr_ist ? reg_wdata[2:0] : 3'h0))
                       | {fe_set, rx_set, tx_set};
         if (wr_tx) tx_data_r <= reg_wdata;
      end
   end

   // read mux
   wire [7:0] pc_rd = {baud_doubler_r, frame_error_select_r, 1'b0, power_off_flag_r,
                       gp1_r, gp0_r, power_down_request_r, sleep_cpu_request_r};
   wire [7:0] sc_rd = {sc7_is_fe ? framing_error_flag_r : serial_mode_bit0_r,
                       serial_mode_bit1_r, multiproc_address_filter_r, rx_enable_r,
                       tx_ninth_bit_r, rx_ninth_bit_r, tx_done_flag_r, rx_done_flag_r};
   wire [7:0] rd_mux = (reg_addr == POWER_CONTROL_ADDR) ? pc_rd
                     : (reg_addr == SERIAL_PORT_CONTROL_ADDR) ? sc_rd
                     : (reg_addr == SLAVE_ADDRESS_ADDR) ? slave_address_r
                     : (reg_addr == SLAVE_ADDRESS_MASK_ADDR) ? slave_address_mask_r
                     : (reg_addr == BAUD_RELOAD_ADDR) ? reload_r[7:0]
                     : (reg_addr == TX_DATA_ADDR) ? tx_data_r
                     : (reg_addr == RX_DATA_ADDR) ? rx_data_r
                     : (reg_addr == IRQ_STATUS_ADDR) ? {5'h00, irq_status_r}
                     : (reg_addr == IRQ_MASK_ADDR) ? {5'h00, irq_mask_r} : 8'h00;
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) rdata_r <= 8'h00;
      else rdata_r <= reg_read ? rd_mux : 8'h00;
   end

   assign reg_rdata          = rdata_r;
   assign tx_pin             = (mode == MODE_SHIFT) ? 1'b1 : tx_pin_r;
   assign shift_clock_out    = (mode == MODE_SHIFT) ? sclk_r : 1'b1;
   assign shift_data_out     = tx_shift_r[0];
   assign shift_data_oe      = (mode == MODE_SHIFT) && tx_busy_r;
   assign power_down_request = power_down_request_r;
   assign sleep_cpu_request  = sleep_cpu_request_r;
   assign irq                = |(irq_status_r & irq_mask_r);
endmodule // serial_port_control_status

/* File: logic/serial_port_pkg.sv */
package serial_port_pkg;
   // register offsets
   localparam logic [7:0] POWER_CONTROL_ADDR       = 8'h87;
   localparam logic [7:0] SERIAL_PORT_CONTROL_ADDR = 8'h98;
   localparam logic [7:0] SLAVE_ADDRESS_ADDR       = 8'hA9;
   localparam logic [7:0] SLAVE_ADDRESS_MASK_ADDR  = 8'hB9;
   localparam logic [7:0] BAUD_RELOAD_ADDR         = 8'hC0;
   localparam logic [7:0] TX_DATA_ADDR             = 8'hC1;
   localparam logic [7:0] RX_DATA_ADDR             = 8'hC2;
   localparam logic [7:0] IRQ_STATUS_ADDR          = 8'hC3;
   localparam logic [7:0] IRQ_MASK_ADDR            = 8'hC4;
   // power control fields
   localparam int PC_BAUD_DOUBLER   = 7;
   localparam int PC_FRAME_ERR_SEL  = 6;
   localparam int PC_POWER_OFF      = 4;
   localparam int PC_GP1            = 3;
   localparam int PC_GP0            = 2;
   localparam int PC_POWER_DOWN     = 1;
   localparam int PC_SLEEP          = 0;
   // serial control fields
   localparam int SC_BIT7           = 7;
   localparam int SC_MODE1          = 6;
   localparam int SC_ADDR_FILTER    = 5;
   localparam int SC_RX_ENABLE      = 4;
   localparam int SC_TX_NINTH       = 3;
   localparam int SC_RX_NINTH       = 2;
   localparam int SC_TX_DONE        = 1;
   localparam int SC_RX_DONE        = 0;
   // interrupt status fields
   localparam int IRQ_TX_DONE       = 0;
   localparam int IRQ_RX_DONE       = 1;
   localparam int IRQ_FRAME_ERR     = 2;
   // reset values
   localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
   localparam logic [7:0] SERIAL_CONTROL_RESET = 8'h00;
   // timing: oscillator divisors
   localparam int SHIFT_DIV         = 12;
   localparam int FIXED_DIV_NORMAL  = 64;
   localparam int FIXED_DIV_DOUBLE  = 32;
   localparam int OVERSAMPLE        = 16;
   localparam int TIMER_PRESCALE    = 2;
   typedef enum logic [1:0] {MODE_SHIFT, MODE_UART8, MODE_UART9_FIXED, MODE_UART9_VAR} mode_t;
endpackage

/* File: test/serial_port_monitor.sv */
`timescale 1ns/1ps
module serial_port_monitor (
   // clock and resets
   input wire logic       clock,
   input wire logic       rstn,
   input wire logic       cold_reset_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic [7:0] reg_rdata,
   // line, requests, interrupt
   input wire logic       tx_pin,
   input wire logic       power_down_request,
   input wire logic       sleep_cpu_request,
   input wire logic       irq
);
   import serial_port_pkg::*;
   logic [7:0] power_control_r;
   logic [6:3] serial_port_control_r;
   logic       pof_r;
   logic       mode0_r;
   wire logic  power_control_wr = reg_write && (reg_addr == POWER_CONTROL_ADDR);
   wire logic  serial_port_control_wr = reg_write && (reg_addr == SERIAL_PORT_CONTROL_ADDR);
   wire logic  power_control_rd = reg_read && (reg_addr == POWER_CONTROL_ADDR);
   wire logic  serial_port_control_rd = reg_read && (reg_addr == SERIAL_PORT_CONTROL_ADDR);
   // shadow of the power-off flag, untouched by warm reset
   always_ff @(posedge clock or negedge cold_reset_n) begin
      if (!cold_reset_n) pof_r <= 1'b1;
      else if (power_control_wr) pof_r <= reg_wdata[PC_POWER_OFF];
   end
   // shadow of software-owned bits
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         power_control_r <= 8'h00;
         serial_port_control_r <= 4'h0;
         mode0_r <= 1'b0;
      end else begin
         if (power_control_wr) power_control_r <= reg_wdata;
         if (serial_port_control_wr) serial_port_control_r <= reg_wdata[6:3];
         if (serial_port_control_wr && !power_control_r[PC_FRAME_ERR_SEL]) mode0_r <= reg_wdata[SC_BIT7];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   AST_POF_READ: assert property (power_control_rd |=> reg_rdata[PC_POWER_OFF] == $past(pof_r))
      else $error("power-off flag reads wrong");
   AST_POWER_CONTROL_READ: assert property (
      power_control_rd |=> (reg_rdata & 8'hCF) == ($past(power_control_r) & 8'hCF))
      else $error("power control reads wrong");
   AST_PD_LEVEL: assert property (power_control_wr |=> power_down_request == power_control_r[PC_POWER_DOWN])
      else $error("power-down request wrong after write");
   AST_SLEEP_HOLD: assert property (!power_control_wr |=> $stable(sleep_cpu_request))
      else $error("sleep request moved without write");
   AST_SERIAL_PORT_CONTROL_READ: assert property (serial_port_control_rd |=> reg_rdata[6:3] == $past(serial_port_control_r))
      else $error("serial control bits read wrong");
   AST_MODE0_VIEW: assert property (
      serial_port_control_rd && !power_control_r[PC_FRAME_ERR_SEL] |=> reg_rdata[SC_BIT7] == $past(mode0_r))
      else $error("bit 7 does not show mode bit 0");
   AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   AST_START_BIT: assert property ($fell(tx_pin) |-> !tx_pin [*8])
      else $error("start bit too short");
   COV_POWER_CONTROL_READ: cover property (power_control_rd);
   COV_TX_FRAME: cover property ($fell(tx_pin));
   COV_IRQ: cover property ($rose(irq));
endmodule // serial_port_monitor

bind serial_port_control_status serial_port_monitor u_monitor (
   .clock(clock), .rstn(rstn), .cold_reset_n(cold_reset_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .tx_pin(tx_pin), .power_down_request(power_down_request),
   .sleep_cpu_request(sleep_cpu_request), .irq(irq)
);

/* File: test/serial_node_model.sv */
`timescale 1ns/1ps
module serial_node_model #(
   parameter int BIT_CYCLES = 32
) (
   // clock
   input  wire logic       clock,
   // frame to send: start, nine bits lsb first, stop
   input  wire logic       send,
   input  wire logic [8:0] send_bits,
   input  wire logic       bad_stop,
   output logic            rx_line,
   // frame heard from the device
   input  wire logic       tx_line,
   output logic [8:0]      heard_bits
);
   initial begin
      rx_line = 1'b1;
      forever begin
         @(posedge clock);
         if (send) begin
            for (int i = 0; i < 11; i++) begin
               rx_line <= (i == 0) ? 1'b0 : (i == 10) ? !bad_stop : send_bits[i-1];
               repeat (BIT_CYCLES) @(posedge clock);
            end
            rx_line <= 1'b1;
         end
      end
   end
   // samples mid-bit after the start edge
   initial begin
      heard_bits = 9'h000;
      forever begin
         @(negedge tx_line);
         repeat (BIT_CYCLES / 2) @(posedge clock);
         for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYCLES) @(posedge clock);
            heard_bits[i] <= tx_line;
         end
      end
   end
endmodule // serial_node_model

/* File: test/serial_port_control_status_tb_top.sv */
`timescale 1ns/1ps
module serial_port_control_status_tb_top;
   import serial_port_pkg::*;
   localparam int BITC = FIXED_DIV_DOUBLE;
   logic       clock = 1'b0;
   logic       rstn = 1'b0;
   logic       cold_reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_write = 1'b0;
   logic       reg_read = 1'b0;
   logic [7:0] reg_rdata;
   logic       rx_pin, tx_pin, irq, power_down_request, sleep_cpu_request;
   logic       shift_clock_out, shift_data_out, shift_data_oe;
   logic       send = 1'b0;
   logic [8:0] send_bits = 9'h000;
   logic       bad_stop = 1'b0;
   logic [8:0] heard_bits;
   logic [7:0] v, w, sa, b;
   logic       n;
   int         bad_count = 0;
   int         check_count = 0;
   int         k;
   always #20 clock = ~clock;
   serial_port_control_status u_dut (
      .clock(clock), .rstn(rstn), .cold_reset_n(cold_reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin),
      .shift_clock_out(shift_clock_out), .shift_data_out(shift_data_out),
      .shift_data_oe(shift_data_oe), .power_down_request(power_down_request),
      .sleep_cpu_request(sleep_cpu_request), .irq(irq)
   );
   serial_node_model #(.BIT_CYCLES(BITC)) u_node (
      .clock(clock), .send(send), .send_bits(send_bits), .bad_stop(bad_stop),
      .rx_line(rx_pin), .tx_line(tx_pin), .heard_bits(heard_bits)
   );
   task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic warm_reset(input logic cold);
      @(posedge clock);
      rstn <= 1'b0;
      cold_reset_n <= !cold;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      cold_reset_n <= 1'b1;
   endtask
   task automatic frame(input logic [8:0] bits, input logic bad);
      @(posedge clock);
      send <= 1'b1;
      send_bits <= bits;
      bad_stop <= bad;
      @(posedge clock);
      send <= 1'b0;
      repeat (12 * BITC) @(posedge clock);
   endtask
   // receive-done expected for a frame under filtering
   function automatic logic want_rx(input logic [7:0] d, input logic nb, input logic [7:0] s,
                                    input logic [7:0] m, input logic [7:0] sc);
      logic [7:0] bc;
      bc = s | m;
      return sc[4] && (!sc[5] || (nb && (((d & m) == (s & m)) || ((d & bc) == bc))));
   endfunction
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clock);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h744e8717));
      warm_reset(1'b1);
      rd(POWER_CONTROL_ADDR);
      chk("power_control cold", {1'b0, v & 8'hDF}, 9'h010);
      for (int i = 0; i < 4; i++) begin
         w = (8'($urandom) & 8'hEF) | (i[0] ? 8'h00 : 8'h10);
         w[5] = 1'b0;
         wr(POWER_CONTROL_ADDR, w);
         chk("requests", {7'h00, power_down_request, sleep_cpu_request}, {7'h00, w[1:0]});
         warm_reset(1'b0);
         rd(POWER_CONTROL_ADDR);
         chk("power_control warm", {1'b0, v & 8'hDF}, {1'b0, w & 8'h10});
      end
      warm_reset(1'b1);
      rd(POWER_CONTROL_ADDR);
      chk("pof cold again", {8'h00, v[4]}, 9'h001);
      $display("test power control done");
      wr(POWER_CONTROL_ADDR, 8'h00);
      for (int m = 0; m < 4; m++) begin
         wr(SERIAL_PORT_CONTROL_ADDR, {m[1], m[0], 6'h18});
         rd(SERIAL_PORT_CONTROL_ADDR);
         chk("mode", {1'b0, v & 8'hF8}, {1'b0, m[1], m[0], 6'h18});
      end
      wr(POWER_CONTROL_ADDR, 8'h80);
      wr(SERIAL_PORT_CONTROL_ADDR, 8'h90);
      frame(9'h1A5, 1'b1);
      wr(SERIAL_PORT_CONTROL_ADDR, 8'h90);
      frame(9'h15A, 1'b0);
      rd(RX_DATA_ADDR);
      chk("rx data", {1'b0, v}, 9'h05A);
      rd(SERIAL_PORT_CONTROL_ADDR);
      chk("rx done and ninth", {7'h00, v[2], v[0]}, 9'h003);
      wr(POWER_CONTROL_ADDR, 8'hC0);
      rd(SERIAL_PORT_CONTROL_ADDR);
      chk("framing error held", {8'h00, v[7]}, 9'h001);
      wr(SERIAL_PORT_CONTROL_ADDR, 8'h10);
      rd(SERIAL_PORT_CONTROL_ADDR);
      chk("framing error cleared", {8'h00, v[7]}, 9'h000);
      wr(POWER_CONTROL_ADDR, 8'h80);
      rd(SERIAL_PORT_CONTROL_ADDR);
      chk("mode bit 0 view", {8'h00, v[7]}, 9'h001);
      $display("test framing done");
      w = 8'($urandom);
      n = 1'($urandom);
      wr(IRQ_MASK_ADDR, 8'h01);
      wr(SERIAL_PORT_CONTROL_ADDR, {4'h9, n, 3'h0});
      wr(TX_DATA_ADDR, w);
      for (k = 0; k < 100 && tx_pin !== 1'b0; k++) @(posedge clock) #1;
      for (k = 0; k < 1000 && irq !== 1'b1; k++) @(posedge clock) #1;
      chk("tx done time", {8'h00, k >= 10 * BITC - 1 && k <= 10 * BITC + 3}, 9'h001);
      chk("tx frame", heard_bits, {n, w});
      wr(IRQ_MASK_ADDR, 8'h00);
      chk("irq masked", {8'h00, irq}, 9'h000);
      wr(IRQ_MASK_ADDR, 8'h01);
      chk("irq unmasked", {8'h00, irq}, 9'h001);
      wr(IRQ_STATUS_ADDR, 8'h01);
      chk("irq cleared", {8'h00, irq}, 9'h000);
      $display("test transmit done");
      sa = 8'($urandom) | 8'h80;
      wr(SLAVE_ADDRESS_ADDR, sa);
      wr(SLAVE_ADDRESS_MASK_ADDR, 8'hF0);
      for (int c = 0; c < 6; c++) begin
         w = (c < 4) ? 8'hB0 : (c == 4) ? 8'h80 : 8'h90;
         b = (c == 1) ? 8'hFF : (c == 2) ? {~sa[7:4], 4'h0} : {sa[7:4], 4'($urandom)};
         n = (c == 3 || c == 5) ? 1'b0 : 1'b1;
         wr(SERIAL_PORT_CONTROL_ADDR, w);
         frame({n, b}, 1'b0);
         rd(SERIAL_PORT_CONTROL_ADDR);
         chk("rx done filter", {8'h00, v[0]}, {8'h00, want_rx(b, n, sa, 8'hF0, w)});
      end
      $display("test address filter done");
      wr(SERIAL_PORT_CONTROL_ADDR, 8'h10);
      w = 8'($urandom);
      wr(TX_DATA_ADDR, w);
      chk("shift oe", {8'h00, shift_data_oe}, 9'h001);
      for (int i = 0; i < 8; i++) begin
         @(negedge shift_clock_out);
         b = {shift_data_out, b[7:1]};
      end
      repeat (40) @(posedge clock);
      #1;
      chk("shift byte", {1'b0, b}, {1'b0, w});
      chk("shift idle", {7'h00, shift_data_oe, shift_clock_out}, 9'h001);
      rd(SERIAL_PORT_CONTROL_ADDR);
      chk("shift done flags", {7'h00, v[1:0]}, 9'h003);
      rd(RX_DATA_ADDR);
      chk("shift rx data", {1'b0, v}, 9'h0FF);
      $display("test shift register done");
      tally_and_finish();
   end
endmodule // serial_port_control_status_tb_top
